/* File: hdl/bft_tables.sv */
// Purpose: Pattern and line tables with a symbol player, Wishbone slave
// Assumes: Synchronous active-high reset, one 250 MHz clock
// Notes:   Ack one cycle after the request; reads answer from latched address
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module bft_tables #(
    parameter int PAT_DEPTH  = bft_pkg::PAT_DEPTH,
    parameter int LINE_DEPTH = bft_pkg::LINE_DEPTH
) (
    input  wire logic        clk,         // 250 MHz clock
    input  wire logic        rst,         // Sync reset, active high
    input  wire logic        wb_cyc_i,    // Bus cycle
    input  wire logic        wb_stb_i,    // Strobe
    input  wire logic        wb_we_i,     // Write enable
    input  wire logic [7:0]  wb_adr_i,    // Byte address
    input  wire logic [3:0]  wb_sel_i,    // Byte lanes
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic      [31:0] wb_dat_o,    // Read data
    output logic             wb_ack_o,    // Acknowledge
    output logic             pos_drive_symbol, // Positive drive out
    output logic             neg_drive_symbol, // Negative drive out
    output logic             trsw_en,     // T/R switch enable
    output logic      [12:0] line_delay,  // Line transmit delay
    output logic             serial_out   // Serial data out, MSB first
);
    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [15:0] pat_mem [PAT_DEPTH];
    logic [23:0] line_mem [LINE_DEPTH];
    logic [16:0] addr_q, addr_d;
    logic [31:0] dat_q, dat_d;
    logic        ack_q, ack_d;
    logic [15:0] div_q, div_d, cnt_q, cnt_d;
    logic [15:0] word_q, word_d;
    logic [2:0]  sym_q, sym_d;
    logic [9:0]  pidx_q, pidx_d;
    logic        pos_q, pos_d, neg_q, neg_d, trsw_q, trsw_d;
    logic [12:0] ldelay_q, ldelay_d;
    logic        stop_q, stop_d;
    logic [23:0] sh_q, sh_d;
    logic [4:0]  shc_q, shc_d;
    logic        sout_q, sout_d;
    bft_pkg::bft_state_e st_q, st_d;
    logic [23:0] start_word;
    logic        start_ok;

    wire req  = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr   = req & wb_we_i;
    wire is_line = addr_q[bft_pkg::ADDR_SEL_BIT];
    wire pat_hit  = (32'(addr_q[15:0]) < PAT_DEPTH);
    wire line_hit = (32'(addr_q[15:0]) < LINE_DEPTH);
    wire step = (cnt_q == 16'h0000);

    // Line word named by a start request, and whether its index is in range
    assign start_word = line_mem[wb_dat_i[28:18]];
    assign start_ok   = wr && wb_adr_i == bft_pkg::OFS_CTRL && wb_dat_i[17]
                        && (32'(wb_dat_i[28:18]) < LINE_DEPTH);

    // Symbol pair of an entry: symbol 0 in 15:14 down to symbol 7 in 1:0
    function automatic logic [1:0] sym_pair(input logic [15:0] w, input logic [2:0] i);
        sym_pair = w[4'(14 - 2 * int'(i)) +: 2]; // see R2 see R3
    endfunction

    // ------------------------------------------------------------------
    // Bus slave next state
    // ------------------------------------------------------------------
    always_comb begin
        addr_d = addr_q;
        dat_d  = dat_q;
        ack_d  = req;
        div_d  = div_q;
        stop_d = 1'b0;
        sh_d   = sh_q;
        shc_d  = shc_q;
        sout_d = sout_q;
        if (shc_q != 5'h00) begin
            sout_d = sh_q[23];                         // see R10
            sh_d   = {sh_q[22:0], 1'b0};
            shc_d  = shc_q - 5'h01;
        end
        if (req) begin
            case (wb_adr_i)
                bft_pkg::OFS_ADDR: begin
                    if (wr) addr_d = wb_dat_i[16:0];   // see R9
                    dat_d = {15'h0000, addr_q};
                end
                bft_pkg::OFS_DATA: begin
                    if (is_line)                       // see R9
                        dat_d = line_hit ? {8'h00, line_mem[addr_q[10:0]]} : 32'h0;
                    else
                        dat_d = pat_hit ? {16'h0000, pat_mem[addr_q[9:0]]} : 32'h0;
                end
                bft_pkg::OFS_CTRL: begin
                    if (wr) begin
                        div_d  = wb_dat_i[15:0];
                        stop_d = wb_dat_i[16];
                    end
                    dat_d = {16'h0000, div_q};
                end
                bft_pkg::OFS_STATUS:
                    dat_d = {16'h0000, 3'h0, ldelay_q};
                bft_pkg::OFS_SERIAL: begin
                    // Index past depth starts no shift
                    if (wr && (is_line ? line_hit : pat_hit)) begin
                        sh_d  = is_line ? line_mem[addr_q[10:0]]
                                        : {pat_mem[addr_q[9:0]], 8'h00};
                        shc_d = is_line ? 5'(bft_pkg::LINE_WIDTH)  // see R4
                                        : 5'(bft_pkg::PAT_WIDTH);  // see R1
                    end
                    dat_d = {27'h0, shc_q};
                end
                default: dat_d = bft_pkg::UNMAPPED;
            endcase
        end
    end

    // Table writes, byte lanes honoured
    always_ff @(posedge clk) begin
        if (wr && wb_adr_i == bft_pkg::OFS_DATA) begin
            if (is_line && line_hit) begin             // see R4
                if (wb_sel_i[0]) line_mem[addr_q[10:0]][7:0]   <= wb_dat_i[7:0];
                if (wb_sel_i[1]) line_mem[addr_q[10:0]][15:8]  <= wb_dat_i[15:8];
                if (wb_sel_i[2]) line_mem[addr_q[10:0]][23:16] <= wb_dat_i[23:16];
            end else if (!is_line && pat_hit) begin    // see R1
                if (wb_sel_i[0]) pat_mem[addr_q[9:0]][7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) pat_mem[addr_q[9:0]][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Player next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; word_d = word_q; sym_d = sym_q;
        pidx_d = pidx_q; pos_d = pos_q; neg_d = neg_q;
        trsw_d = trsw_q; ldelay_d = ldelay_q;
        case (st_q)
            bft_pkg::BFT_IDLE: begin
                // Out-of-range line index is ignored
                if (start_ok) begin
                    ldelay_d = start_word[bft_pkg::DELAY_MSB:bft_pkg::DELAY_LSB]; // see R5
                    pidx_d   = start_word[bft_pkg::PAD_MSB:bft_pkg::PAD_LSB];     // see R6
                    trsw_d   = start_word[bft_pkg::TRSW_BIT];                     // see R7
                    cnt_d    = 16'h0000;
                    st_d     = bft_pkg::BFT_LOAD;
                end
            end
            bft_pkg::BFT_LOAD: begin
                word_d = pat_mem[pidx_q];                // see R6
                sym_d  = 3'h0;
                // Keep counting so step spacing holds across entries
                cnt_d  = step ? 16'h0000 : cnt_q - 16'h0001; // see R8
                st_d   = bft_pkg::BFT_PLAY;
            end
            bft_pkg::BFT_PLAY: begin
                cnt_d = step ? div_q : cnt_q - 16'h0001;
                if (step) begin
                    {pos_d, neg_d} = sym_pair(word_q, sym_q); // see R8
                    sym_d = sym_q + 3'h1;
                    if (sym_q == 3'h7) begin
                        pidx_d = pidx_q + 10'h001;
                        st_d   = bft_pkg::BFT_LOAD;
                    end
                end
            end
            default: st_d = bft_pkg::BFT_IDLE;
        endcase
        if (stop_q) begin
            st_d = bft_pkg::BFT_IDLE; pos_d = 1'b0; neg_d = 1'b0; trsw_d = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= '0; dat_q <= bft_pkg::RST_ZERO; ack_q <= 1'b0;
            div_q <= bft_pkg::DIV_DEFAULT; stop_q <= 1'b0;
            sh_q <= '0; shc_q <= '0; sout_q <= 1'b0;
            st_q <= bft_pkg::BFT_IDLE; cnt_q <= '0; word_q <= '0; sym_q <= '0;
            pidx_q <= '0; pos_q <= 1'b0; neg_q <= 1'b0; trsw_q <= 1'b0; ldelay_q <= '0;
        end else begin
            addr_q <= addr_d; dat_q <= dat_d; ack_q <= ack_d;
            div_q <= div_d; stop_q <= stop_d;
            sh_q <= sh_d; shc_q <= shc_d; sout_q <= sout_d;
            st_q <= st_d; cnt_q <= cnt_d; word_q <= word_d; sym_q <= sym_d;
            pidx_q <= pidx_d; pos_q <= pos_d; neg_q <= neg_d;
            trsw_q <= trsw_d; ldelay_q <= ldelay_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign pos_drive_symbol = pos_q;
    assign neg_drive_symbol = neg_q;
    assign trsw_en = trsw_q;
    assign line_delay = ldelay_q;
    assign serial_out = sout_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst) // see R9
        wb_cyc_i && wb_stb_i && !ack_q |=> ack_q) else $error("ack missing");
    a_ack_drops: assert property (@(posedge clk) disable iff (rst)
        ack_q |=> !ack_q) else $error("ack held");
    a_first_pair: assert property (@(posedge clk) disable iff (rst || stop_q) // see R2
        st_q == bft_pkg::BFT_PLAY && step && sym_q == 3'h0
        |=> pos_q == word_q[15] && neg_q == word_q[14]) else $error("first symbol");
    a_last_pair: assert property (@(posedge clk) disable iff (rst || stop_q) // see R3
        st_q == bft_pkg::BFT_PLAY && step && sym_q == 3'h7
        |=> pos_q == $past(word_q[1]) && neg_q == $past(word_q[0])) else $error("last symbol");
    a_sym_advance: assert property (@(posedge clk) disable iff (rst || stop_q) // see R8
        st_q == bft_pkg::BFT_PLAY && step && sym_q != 3'h7
        |=> sym_q == $past(sym_q) + 3'h1) else $error("symbol order");
    a_shift_len: assert property (@(posedge clk) disable iff (rst) // see R4
        shc_q > 5'h18 |-> 1'b0) else $error("shift length");
    a_shift_msb: assert property (@(posedge clk) disable iff (rst) // see R10
        shc_q != 5'h00 && !(wr && wb_adr_i == bft_pkg::OFS_SERIAL)
        |=> sout_q == $past(sh_q[23])) else $error("msb first");
    a_play_load: assert property (@(posedge clk) disable iff (rst || stop_q) // see R6
        st_q == bft_pkg::BFT_LOAD |=> word_q == $past(pat_mem[pidx_q])) else $error("fetch");
    a_stop_quiet: assert property (@(posedge clk) disable iff (rst) // see R8
        stop_q |=> !pos_q && !neg_q && st_q == bft_pkg::BFT_IDLE) else $error("stop outputs");
    a_line_fields: assert property (@(posedge clk) disable iff (rst || stop_q) // see R7
        st_q == bft_pkg::BFT_IDLE && start_ok
        |=> trsw_q == $past(start_word[bft_pkg::TRSW_BIT])
            && ldelay_q == $past(start_word[bft_pkg::DELAY_MSB:bft_pkg::DELAY_LSB]))
        else $error("line fields");
    c_play_line: cover property (@(posedge clk) st_q == bft_pkg::BFT_PLAY && sym_q == 3'h7);
    c_serial_line: cover property (@(posedge clk) shc_q == 5'h18);
    c_play_stop: cover property (@(posedge clk) stop_q && st_q == bft_pkg::BFT_PLAY);
    c_read_data: cover property (@(posedge clk) ack_q && wb_adr_i == bft_pkg::OFS_DATA);
endmodule // bft_tables

/* File: inc/bft_pkg.sv */
// Purpose: Constants for the beamforming table block (pattern and line tables)
// Assumes: Wishbone classic slave, 32-bit data, single clock
// Notes:   Table storage is flip-flops; sizes are module parameters
//
// How it works
// R1: Each channel's pattern table holds 1024 entries of 16 bits, each moved as two bytes.
// R2: The first symbol of a pattern entry sits in bits 15:14, positive drive in 15, negative in 14.
// R3: Later symbols take descending bit pairs down to bits 1:0, positive drive bit first.
// R4: The line table holds 1536 words of 24 bits, each moved as three bytes.
// R5: Bits 23:11 of a line word hold the channel's transmit delay for the line.
// R6: Bits 10:1 of a line word pick the pattern entry the channel starts from.
// R7: Bit 0 of a line word turns the channel's transmit/receive switch on when set.
// R8: The eight symbols of an entry are played first to eighth, one per time-base step.
// R9: A table read takes two transfers: one sets the address, the next returns the data.
// R10: Table words are shifted most significant bit first.
package bft_pkg;
    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int PAT_DEPTH  = 1024;
    localparam int PAT_WIDTH  = 16;
    localparam int LINE_DEPTH = 1536;
    localparam int LINE_WIDTH = 24;
    localparam int SYMBOLS    = 8;
    // ------------------------------------------------------------------
    // Line word fields
    // ------------------------------------------------------------------
    localparam int DELAY_MSB = 23;
    localparam int DELAY_LSB = 11;
    localparam int PAD_MSB = 10;
    localparam int PAD_LSB = 1;
    localparam int TRSW_BIT = 0;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR   = 8'h00; // Table select and index
    localparam logic [7:0] OFS_DATA   = 8'h04; // Data at latched address
    localparam logic [7:0] OFS_CTRL   = 8'h08; // Play control
    localparam logic [7:0] OFS_STATUS = 8'h0C; // Transmit delay of the current line
    localparam logic [7:0] OFS_SERIAL = 8'h10; // Serial shift of data word
    localparam int ADDR_SEL_BIT = 16;          // 0 pattern, 1 line table
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED = 32'hDEAD_0000;
    localparam logic [15:0] DIV_DEFAULT = 16'h0003;

    typedef enum logic [1:0] {
        BFT_IDLE = 2'b00,
        BFT_LOAD = 2'b01,
        BFT_PLAY = 2'b11
    } bft_state_e;
endpackage

/* File: test/bft_serial_rx.sv */
// Purpose: Host-side capture of the serial table word
// Assumes: One bit per clock, first bit sampled on the edge where go is seen
// Notes:   done stays high until the next go
`timescale 1ns/1ps
module bft_serial_rx (
    input  wire logic        clk,   // Bench clock
    input  wire logic        rst,   // Sync reset
    input  wire logic        go,    // Capture start pulse
    input  wire logic [4:0]  nbits, // Bits to take
    input  wire logic        sdata, // Serial line
    output logic      [23:0] word,  // Captured word
    output logic             done   // Capture finished
);
    logic [4:0] left_q;

    // Shift in one bit per cycle, earliest bit ends up on top
    always_ff @(posedge clk) begin
        if (rst || go) begin
            left_q <= go ? nbits - 5'h01 : 5'h00;
            word   <= {23'h000000, go & sdata};
            done   <= 1'b0;
        end else if (left_q != 5'h00) begin
            left_q <= left_q - 5'h01;
            word   <= {word[22:0], sdata};
            done   <= (left_q == 5'h01);
        end
    end
endmodule // bft_serial_rx

/* File: test/test_bft_tables.sv */
// Purpose: Self-checking bench for the table block
// Assumes: Wishbone master, one idle cycle between requests
// Notes:   Reads and played symbols are checked against queued notes
`timescale 1ns/1ps
module test_bft_tables;
    typedef struct {string nm; logic [31:0] v;} bft_exp_s;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0;
    logic [7:0]  adr = 8'h00;
    logic [4:0]  nb = 5'h10;
    logic [31:0] wdat = 32'h0, rdat, pat, lw;
    logic        ack, pos, neg, trsw, sout, done;
    logic [12:0] ldelay;
    logic [3:0]  sel = 4'hF;
    logic [23:0] word;
    logic [1:0]  last_sym = 2'b00;
    bft_exp_s    rd_q[$];
    logic [1:0]  sym_q[$];
    int          miscompares = 0, n_tests = 0, cyc_n = 0, last_t = 0, div;

    bft_tables bft_tables_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pos_drive_symbol(pos), .neg_drive_symbol(neg), .trsw_en(trsw),
        .line_delay(ldelay), .serial_out(sout));
    bft_serial_rx bft_serial_rx_i (.clk(clk), .rst(rst), .go(go), .nbits(nb),
        .sdata(sout), .word(word), .done(done));

    always #2 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; a read notes its expected data first
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input string nm, input logic g = 1'b0, input logic [3:0] s = 4'hF);
        bft_exp_s e;
        e.nm = nm;
        e.v  = d;
        if (!w) rd_q.push_back(e);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        go  <= g;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Read watcher: oldest note against the data seen with ack
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
            bft_exp_s e;
            e = rd_q.pop_front();
            check(e.nm, rdat, e.v);
        end
    end

    // Symbol watcher: each change of the drive pair takes one note
    always @(posedge clk) begin
        cyc_n++;
        if ({pos, neg} !== last_sym && sym_q.size() > 0) begin
            if (sym_q.size() < 9) check("step", cyc_n - last_t, div + 1);
            check("symbol", 32'({pos, neg}), 32'(sym_q.pop_front()));
            last_t = cyc_n;
        end
        last_sym = {pos, neg};
    end

    initial begin
        void'($urandom(66));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(0, bft_pkg::OFS_CTRL, 32'(bft_pkg::DIV_DEFAULT), "div reset");
        wb(0, bft_pkg::OFS_STATUS, bft_pkg::RST_ZERO, "status reset");
        wb(0, 8'h14, bft_pkg::UNMAPPED, "unmapped");
        $display("reset test done");
        for (int t = 0; t < 2; t++) begin
            int dep;
            logic [31:0] m;
            dep = t ? bft_pkg::LINE_DEPTH : bft_pkg::PAT_DEPTH;
            m   = t ? 32'h00FF_FFFF : 32'h0000_FFFF;
            lw  = $urandom & m;
            nb <= t ? 5'h18 : 5'h10;
            wb(1, bft_pkg::OFS_ADDR, 32'((t << bft_pkg::ADDR_SEL_BIT) + $urandom % dep), "");
            wb(1, bft_pkg::OFS_DATA, lw, "");
            wb(0, bft_pkg::OFS_DATA, lw, "table word");
            wb(1, bft_pkg::OFS_SERIAL, 32'h0, "", 1'b1);
            @(posedge clk);
            while (done !== 1'b1) @(posedge clk);
            check("serial word", 32'(word), lw);
            wb(1, bft_pkg::OFS_DATA, m, "", 1'b0, 4'h1);
            wb(0, bft_pkg::OFS_DATA, lw | 32'h0000_00FF, "byte lane");
            wb(1, bft_pkg::OFS_ADDR, 32'((t << bft_pkg::ADDR_SEL_BIT) + dep), "");
            wb(1, bft_pkg::OFS_DATA, m, "");
            wb(0, bft_pkg::OFS_DATA, 32'h0, "past depth");
            $display("table %0d test done", t);
        end
        div = 2 + $urandom % 4;
        pat = 32'h0000_9D8E;
        lw  = (($urandom % 32'h2000) << 11) | (32'h28 << 1) | 32'h1;
        wb(1, bft_pkg::OFS_ADDR, 32'h28, "");
        wb(1, bft_pkg::OFS_DATA, pat, "");
        wb(1, bft_pkg::OFS_ADDR, 32'h29, "");
        wb(1, bft_pkg::OFS_DATA, 32'h0, "");
        wb(1, bft_pkg::OFS_ADDR, 32'h0001_0009, "");
        wb(1, bft_pkg::OFS_DATA, lw, "");
        for (int k = 0; k < 8; k++) sym_q.push_back(2'(pat >> (14 - 2 * k)));
        sym_q.push_back(2'b00);
        wb(1, bft_pkg::OFS_CTRL, 32'(div) | 32'h0002_0000 | (32'h9 << 18), "");
        while (sym_q.size() > 0) @(posedge clk);
        check("line delay", 32'(ldelay), lw >> 11);
        check("trsw", 32'(trsw), 32'h1);
        wb(0, bft_pkg::OFS_STATUS, lw >> 11, "status delay");
        wb(1, bft_pkg::OFS_CTRL, 32'(div) | 32'h0001_0000, "");
        wb(0, bft_pkg::OFS_CTRL, 32'(div), "divider");
        check("stopped", 32'({pos, neg}), 32'h0);
        $display("play test done");
        tally_and_finish();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // test_bft_tables
